// ===== timer_a_regs.sv
// timer register front end: wishbone slave, register decode, flags and counter
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
module timer_a_regs
	import timer_a_pkg::*;
#(
	// 1: reprogrammable-memory variant, 0: masked-memory variant
	parameter bit FLASH_VARIANT = 1'b1
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic captureOnePin,
	input wire logic captureTwoPin
);
	logic ack_r;
	logic [31:0] rdData_r;
	logic [7:0] ctrlTwo_r;
	logic [7:0] ctrlOne_r;
	logic [15:0] count_r;
	logic [15:0] capOne_r;
	logic [15:0] capTwo_r;
	logic [4:0] flags_r;
	logic statusSeen_r;
	logic [2:0] syncOne_r;
	logic [2:0] syncTwo_r;
	logic access;
	logic wrAccess;
	logic rdAccess;
	logic wrLane;
	logic [7:0] idx;
	logic [7:0] wrByte;
	logic [7:0] rdByte;
	logic [7:0] statusByte;
	logic capOneEvent;
	logic capTwoEvent;
	logic cmpOneHit;
	logic cmpTwoHit;
	logic overflow;
	logic running;
	logic clrCapOne;
	logic clrCmpOne;
	logic clrOverflow;
	logic clrCapTwo;
	logic clrCmpTwo;

	byte_pair_if cmpOneBus ();
	byte_pair_if cmpTwoBus ();

	// a request is taken in the cycle before ack; ack then blocks a second take
	assign access = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wrLane = wb_sel_i[0];
	assign wrAccess = access & wb_we_i & wrLane;
	assign rdAccess = access & ~wb_we_i;
	// all address bits decoded, so nothing aliases onto the timer range
	assign idx = wb_adr_i;
	assign wrByte = wb_dat_i[7:0];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= access;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrlTwo_r <= CTRL_TWO_RESET;
			ctrlOne_r <= CTRL_ONE_RESET;
		end
		else if (wrAccess)
		begin
			if (idx == IDX_CTRL_TWO)
			begin
				ctrlTwo_r <= wrByte;
			end
			if (idx == IDX_CTRL_ONE)
			begin
				ctrlOne_r <= wrByte;
			end
		end
	end

	// second compare pair accepts writes in both variants
	assign cmpOneBus.wrHigh = wrAccess & (idx == IDX_CMP_ONE_HIGH);
	assign cmpOneBus.wrLow = wrAccess & (idx == IDX_CMP_ONE_LOW);
	assign cmpOneBus.wrData = wrByte;
	assign cmpTwoBus.wrHigh = wrAccess & (idx == IDX_CMP_TWO_HIGH);
	assign cmpTwoBus.wrLow = wrAccess & (idx == IDX_CMP_TWO_LOW);
	assign cmpTwoBus.wrData = wrByte;

	byte_pair_reg #(
		.RESET_VAL(CMP_RESET)
	) cmpOneReg (
		.sys_clk(sys_clk),
		.rst(rst),
		.bp(cmpOneBus)
	);

	byte_pair_reg #(
		.RESET_VAL(CMP_RESET)
	) cmpTwoReg (
		.sys_clk(sys_clk),
		.rst(rst),
		.bp(cmpTwoBus)
	);

	// free-running counter gated by the run bit of control two
	assign running = ctrlTwo_r[CTRL_TWO_RUN];
	assign overflow = running & (count_r == 16'hffff);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			count_r <= CNT_RESET;
		end
		else if (running)
		begin
			count_r <= count_r + 16'h0001;
		end
	end

	// pin inputs pass two flops; the third only feeds the edge detector
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			syncOne_r <= 3'h0;
			syncTwo_r <= 3'h0;
		end
		else
		begin
			syncOne_r <= {syncOne_r[1:0], captureOnePin};
			syncTwo_r <= {syncTwo_r[1:0], captureTwoPin};
		end
	end

	assign capOneEvent = syncOne_r[1] & ~syncOne_r[2];
	// second capture input is ignored in the reprogrammable variant
	assign capTwoEvent = ~FLASH_VARIANT & syncTwo_r[1] & ~syncTwo_r[2];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			capOne_r <= CAP_RESET;
			capTwo_r <= CAP_RESET;
		end
		else
		begin
			if (capOneEvent)
			begin
				capOne_r <= count_r;
			end
			if (capTwoEvent)
			begin
				capTwo_r <= count_r;
			end
		end
	end

	// masked variant compares on the second pair as well
	assign cmpOneHit = running & (count_r == cmpOneBus.value);
	assign cmpTwoHit = ~FLASH_VARIANT & running & (count_r == cmpTwoBus.value);

	// a flag is cleared by reading status, then touching its low register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			statusSeen_r <= 1'b0;
		end
		else if (rdAccess & (idx == IDX_CTRL_STATUS))
		begin
			statusSeen_r <= 1'b1;
		end
		else if (clrCapOne | clrCmpOne | clrOverflow | clrCapTwo | clrCmpTwo)
		begin
			statusSeen_r <= 1'b0;
		end
	end

	assign clrCapOne = statusSeen_r & rdAccess & (idx == IDX_CAP_ONE_LOW);
	assign clrCmpOne = statusSeen_r & wrAccess & (idx == IDX_CMP_ONE_LOW);
	assign clrOverflow = statusSeen_r & rdAccess & (idx == IDX_CNT_LOW);
	// dummy access to either second low register clears its flag
	assign clrCapTwo = statusSeen_r & access & (idx == IDX_CAP_TWO_LOW);
	assign clrCmpTwo = statusSeen_r & access & (idx == IDX_CMP_TWO_LOW);

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			flags_r <= 5'h00;
		end
		else
		begin
			if (capOneEvent)
			begin
				flags_r[FLAG_CAP_ONE - 3] <= 1'b1;
			end
			else if (clrCapOne)
			begin
				flags_r[FLAG_CAP_ONE - 3] <= 1'b0;
			end
			if (cmpOneHit)
			begin
				flags_r[FLAG_CMP_ONE - 3] <= 1'b1;
			end
			else if (clrCmpOne)
			begin
				flags_r[FLAG_CMP_ONE - 3] <= 1'b0;
			end
			if (overflow)
			begin
				flags_r[FLAG_OVERFLOW - 3] <= 1'b1;
			end
			else if (clrOverflow)
			begin
				flags_r[FLAG_OVERFLOW - 3] <= 1'b0;
			end
			if (capTwoEvent)
			begin
				flags_r[FLAG_CAP_TWO - 3] <= 1'b1;
			end
			else if (clrCapTwo)
			begin
				flags_r[FLAG_CAP_TWO - 3] <= 1'b0;
			end
			if (cmpTwoHit)
			begin
				flags_r[FLAG_CMP_TWO - 3] <= 1'b1;
			end
			else if (clrCmpTwo)
			begin
				flags_r[FLAG_CMP_TWO - 3] <= 1'b0;
			end
		end
	end

	assign statusByte = {flags_r, 3'h0};

	always_comb
	begin
		rdByte = READ_NONE;
		unique case (idx)
			IDX_CTRL_TWO: rdByte = ctrlTwo_r;
			IDX_CTRL_ONE: rdByte = ctrlOne_r;
			IDX_CTRL_STATUS: rdByte = statusByte;
			IDX_CAP_ONE_HIGH: rdByte = capOne_r[15:8];
			IDX_CAP_ONE_LOW: rdByte = capOne_r[7:0];
			IDX_CMP_ONE_HIGH: rdByte = cmpOneBus.value[15:8];
			IDX_CMP_ONE_LOW: rdByte = cmpOneBus.value[7:0];
			IDX_CNT_HIGH: rdByte = count_r[15:8];
			IDX_CNT_LOW: rdByte = count_r[7:0];
			IDX_ALT_CNT_HIGH: rdByte = count_r[15:8];
			IDX_ALT_CNT_LOW: rdByte = count_r[7:0];
			IDX_CAP_TWO_HIGH: rdByte = FLASH_VARIANT ? READ_NONE : capTwo_r[15:8];
			IDX_CAP_TWO_LOW: rdByte = FLASH_VARIANT ? READ_NONE : capTwo_r[7:0];
			// stored value hidden in the reprogrammable variant
			IDX_CMP_TWO_HIGH: rdByte = FLASH_VARIANT ? READ_NONE : cmpTwoBus.value[15:8];
			IDX_CMP_TWO_LOW: rdByte = FLASH_VARIANT ? READ_NONE : cmpTwoBus.value[7:0];
			IDX_RESERVED: rdByte = READ_NONE;
			// unmapped addresses read zero as well
			default: rdByte = READ_NONE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rdData_r <= 32'h0000_0000;
		end
		else if (rdAccess)
		begin
			rdData_r <= {24'h00_0000, rdByte};
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdData_r;
endmodule : timer_a_regs
`default_nettype wire

// ===== timer_a_pkg.sv
// constants shared by the timer register front end
`default_nettype none
package timer_a_pkg;
	// register addresses; every byte register sits alone in lane 0 of its own bus word
	localparam logic [7:0] IDX_CTRL_TWO = 8'h31;
	localparam logic [7:0] IDX_CTRL_ONE = 8'h32;
	localparam logic [7:0] IDX_CTRL_STATUS = 8'h33;
	localparam logic [7:0] IDX_CAP_ONE_HIGH = 8'h34;
	localparam logic [7:0] IDX_CAP_ONE_LOW = 8'h35;
	localparam logic [7:0] IDX_CMP_ONE_HIGH = 8'h36;
	localparam logic [7:0] IDX_CMP_ONE_LOW = 8'h37;
	localparam logic [7:0] IDX_CNT_HIGH = 8'h38;
	localparam logic [7:0] IDX_CNT_LOW = 8'h39;
	localparam logic [7:0] IDX_ALT_CNT_HIGH = 8'h3a;
	localparam logic [7:0] IDX_ALT_CNT_LOW = 8'h3b;
	localparam logic [7:0] IDX_CAP_TWO_HIGH = 8'h3c;
	localparam logic [7:0] IDX_CAP_TWO_LOW = 8'h3d;
	localparam logic [7:0] IDX_CMP_TWO_HIGH = 8'h3e;
	localparam logic [7:0] IDX_CMP_TWO_LOW = 8'h3f;
	localparam logic [7:0] IDX_RESERVED = 8'h40;
	// reset values
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [15:0] CMP_RESET = 16'h8000;
	localparam logic [15:0] CNT_RESET = 16'hfffc;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	// control/status flag positions
	localparam int FLAG_CAP_ONE = 7;
	localparam int FLAG_CMP_ONE = 6;
	localparam int FLAG_OVERFLOW = 5;
	localparam int FLAG_CAP_TWO = 4;
	localparam int FLAG_CMP_TWO = 3;
	// control two field: counter run enable
	localparam int CTRL_TWO_RUN = 0;
	// value returned where a read yields nothing defined
	localparam logic [7:0] READ_NONE = 8'h00;
endpackage : timer_a_pkg
`default_nettype wire

// ===== byte_pair_if.sv
// byte-wise write port and 16-bit value of one high/low register pair
`default_nettype none
interface byte_pair_if;
	logic wrHigh;
	logic wrLow;
	logic [7:0] wrData;
	logic [15:0] value;
	modport owner (input wrHigh, input wrLow, input wrData, output value);
	modport user (output wrHigh, output wrLow, output wrData, input value);
endinterface : byte_pair_if
`default_nettype wire

// ===== byte_pair_reg.sv
// 16-bit register written one byte at a time
`default_nettype none
module byte_pair_reg
#(
	parameter logic [15:0] RESET_VAL = 16'h0000
)
(
	input wire logic sys_clk,
	input wire logic rst,
	byte_pair_if.owner bp
);
	logic [15:0] value_r;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			value_r <= RESET_VAL;
		end
		else
		begin
			if (bp.wrHigh)
			begin
				value_r[15:8] <= bp.wrData;
			end
			if (bp.wrLow)
			begin
				value_r[7:0] <= bp.wrData;
			end
		end
	end

	assign bp.value = value_r;
endmodule : byte_pair_reg
`default_nettype wire

// ===== timer_a_chk.sv
// assertion checker for the timer register front end
`default_nettype none
module timer_a_chk
	import timer_a_pkg::*;
#(
	parameter bit FLASH_VARIANT = 1'b1
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic captureOnePin,
	input wire logic captureTwoPin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic take;
	logic rdAck;
	logic [7:0] idx;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rdAck = wb_ack_o && !wb_we_i;
	assign idx = wb_adr_i;
	a_ack_next: assert property (take |=> wb_ack_o) else $error("ack missing");
	a_ack_cause: assert property (wb_ack_o |-> $past(take) ##1 !wb_ack_o) else $error("stray ack");
	a_data_holds: assert property (!take || wb_we_i |=> $stable(wb_dat_o)) else $error("data moved");
	a_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000) else $error("upper bits set");
	a_reserved_zero: assert property (rdAck && idx == IDX_RESERVED |-> wb_dat_o == 32'h0)
		else $error("reserved read not zero");
	a_cap_two_none: assert property (FLASH_VARIANT && rdAck && idx[7:1] == 7'h1e
		|-> wb_dat_o == 32'h0) else $error("capture two present");
	a_flag_two_zero: assert property (FLASH_VARIANT && rdAck && idx == IDX_CTRL_STATUS
		|-> wb_dat_o[4:3] == 2'h0) else $error("second flags set");
	a_cmp_two_hidden: assert property (FLASH_VARIANT && rdAck && idx[7:1] == 7'h1f
		|-> wb_dat_o[7:0] == READ_NONE) else $error("compare two readable");
	c_read: cover property (rdAck);
	c_write: cover property (wb_ack_o && wb_we_i);
	c_status: cover property (rdAck && idx == IDX_CTRL_STATUS && wb_dat_o[7] == 1'b1);
endmodule : timer_a_chk
bind timer_a_regs timer_a_chk #(.FLASH_VARIANT(FLASH_VARIANT)) u_chk (.sys_clk(sys_clk),
	.rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .captureOnePin(captureOnePin), .captureTwoPin(captureTwoPin));
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the timer register front end
`default_nettype none
module tb_top
	import timer_a_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, capOne = 0, capTwo = 0;
	logic ack, ackMasked;
	logic [7:0] adr = 8'h00, rd, rdMasked;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dout, doutMasked;
	int miscompares = 0, check_count = 0;
	timer_a_regs DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
		.wb_ack_o(ack), .captureOnePin(capOne), .captureTwoPin(capTwo));
	// masked-memory variant on the same bus, so every read check compares both variants
	timer_a_regs #(.FLASH_VARIANT(1'b0)) DUT_MASKED (.sys_clk(sys_clk), .rst(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(doutMasked), .wb_ack_o(ackMasked),
		.captureOnePin(capOne), .captureTwoPin(capTwo));
	initial
	begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= i;
		sel <= 4'h1;
		dat <= {24'h0, d};
		// no answer time is assumed; only the watchdog ends a hung wait
		do
		begin
			@(posedge sys_clk);
		end
		while (ack !== 1'b1 || ackMasked !== 1'b1);
		rd = dout[7:0];
		rdMasked = doutMasked[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic compare8(input string nm, input logic [7:0] e, input logic [7:0] seen);
		check_count++;
		if (seen !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask : compare8
	task automatic check8(input string nm, input logic [7:0] i, input logic [7:0] e,
		input logic [7:0] em);
		bus(1'b0, i, 8'h00);
		compare8(nm, e, rd);
		compare8({nm, " masked"}, em, rdMasked);
	endtask : check8
	initial
	begin
		#(25ns * 3000);
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		check8("ctrl two", IDX_CTRL_TWO, CTRL_TWO_RESET, CTRL_TWO_RESET);
		check8("cmp one high", IDX_CMP_ONE_HIGH, 8'h80, 8'h80);
		check8("cnt low", IDX_CNT_LOW, 8'hfc, 8'hfc);
		check8("alt cnt high", IDX_ALT_CNT_HIGH, 8'hff, 8'hff);
		bus(1'b1, IDX_CTRL_ONE, 8'h5a);
		check8("ctrl one", IDX_CTRL_ONE, 8'h5a, 8'h5a);
		bus(1'b1, IDX_CTRL_STATUS, 8'hff);
		bus(1'b1, IDX_CNT_LOW, 8'h11);
		check8("status", IDX_CTRL_STATUS, 8'h00, 8'h00);
		check8("cnt low kept", IDX_CNT_LOW, 8'hfc, 8'hfc);
		bus(1'b1, IDX_CAP_TWO_LOW, 8'h77);
		check8("cap two low", IDX_CAP_TWO_LOW, 8'h00, 8'h00);
		bus(1'b1, IDX_RESERVED, 8'h33);
		check8("reserved", IDX_RESERVED, 8'h00, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, IDX_CMP_ONE_HIGH + 8'(k), 8'h10 * 8'(k));
			bus(1'b1, IDX_CMP_TWO_HIGH + 8'(k), 8'h10 * 8'(k));
		end
		check8("cmp two low", IDX_CMP_TWO_LOW, READ_NONE, 8'h10);
		check8("cmp one low", IDX_CMP_ONE_LOW, 8'h10, 8'h10);
		// the counter passes both compare values and wraps past ffff
		bus(1'b1, IDX_CTRL_TWO, 8'h01);
		@(posedge sys_clk);
		capOne <= 1'b1;
		capTwo <= 1'b1;
		repeat (40) @(posedge sys_clk);
		check8("flags", IDX_CTRL_STATUS, 8'he0, 8'hf8);
		bus(1'b0, IDX_CAP_TWO_LOW, 8'h00);
		check8("flags mid", IDX_CTRL_STATUS, 8'he0, 8'he8);
		bus(1'b1, IDX_CMP_TWO_LOW, 8'h00);
		check8("flags after", IDX_CTRL_STATUS, 8'he0, 8'he0);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
